// File: hdl/fac_top.sv
// Flash access control, controller clock divider and block write/erase protection
`timescale 1ns/10ps
`default_nettype none
`include "fac_map.svh"

// Summary of operation
// [RULE1] Wait field bits 7:5 inserts that many wait states, codes 000 to 101.
// [RULE2] Codes 110 and 111 insert six and seven wait states.
// [RULE3] Reset selects four wait states.
// [RULE4] Enable bit 3 low blocks flash memory-space accesses; high permits them.
// [RULE5] Register reads and writes keep working while memory-space access is off.
// [RULE6] Controller clock is system clock divided by the 8-bit divider value.
// [RULE7] Software loads 1, 2 or 3 for the listed low clock ranges.
// [RULE8] From 616 kHz to 50 MHz software loads ceiling of MHz times 5.1.
// [RULE9] Divider holds 01h to FFh and resets to 01h.
// [RULE10] Divider is written only while unlocked by the key sequence.
// [RULE11] Each of eight mask bits guards one 32 KB block; 1 blocks writes and erases.
// [RULE12] Mask bit n covers the block starting at n times 8000h.
// [RULE13] Reset sets every mask bit.
// [RULE14] Boot block is protected when the protect pin or mask bit 0 is set.
// [RULE15] Mask is writable only while unlocked.
// [RULE16] A mask write while locked forces the mask to FFh.
// [RULE17] Information page has no guard; mass erase skips it unless selected.
// [RULE18] Writes to a protected block are dropped and flag a write violation.
// [RULE19] Reserved control bits read zero and ignore writes.
// [RULE20] Divider counter reloads, giving one enable per divider-value cycles.
module fac_top #(
    parameter int ADDR_W = 18
) (
    input  wire logic              core_clk_i,
    input  wire logic              rst_i,
    input  wire logic [7:0]        io_addr_i,
    input  wire logic              io_wr_i,
    input  wire logic              io_rd_i,
    input  wire logic [7:0]        io_wdata_i,
    output logic      [7:0]        io_rdata_o,
    input  wire logic              key_unlocked_i,
    input  wire logic              wp_pin_i,
    input  wire logic              info_page_select_i,
    input  wire logic              mem_req_i,
    input  wire logic              mem_we_i,
    input  wire logic [ADDR_W-1:0] mem_addr_i,
    output logic                   mem_ready_o,
    output logic                   mem_block_o,
    output logic                   flash_wr_o,
    output logic                   write_viol_o,
    input  wire logic              page_erase_i,
    input  wire logic              mass_erase_i,
    output logic                   page_erase_go_o,
    output logic                   page_erase_viol_o,
    output logic                   mass_erase_go_o,
    output logic                   mass_erase_viol_o,
    output logic                   info_erase_o,
    output logic                   ctrl_clk_en_o,
    output logic      [7:0]        eff_protect_o
);

    // Registers
    logic [7:0]          ctrl_reg,    ctrl_next;
    logic [7:0]          div_reg,     div_next;
    logic [7:0]          prot_reg,    prot_next;
    logic [7:0]          rdata_reg,   rdata_next;
    // Protect pin synchroniser
    logic                wp_meta_reg;
    logic                wp_sync_reg;
    // Access sequencer
    fac_pkg::fac_state_t state_reg,   state_next;
    logic [2:0]          wcnt_reg,    wcnt_next;
    logic                we_lat_reg,  we_lat_next;
    logic                hit_lat_reg, hit_lat_next;
    // Controller clock divider
    logic [7:0]          dcnt_reg,    dcnt_next;
    // Registered event pulses
    logic                fwr_reg,     fwr_next;
    logic                wviol_reg,   wviol_next;
    logic                pgo_reg,     pgo_next;
    logic                pviol_reg,   pviol_next;
    logic                mgo_reg,     mgo_next;
    logic                mviol_reg,   mviol_next;
    logic                info_reg,    info_next;
    // Decoded strobes and protection view
    logic [7:0]          eff_prot;
    logic                mem_en;
    logic [2:0]          blk_idx;
    logic                blk_hit;
    logic                wr_ctrl;
    logic                wr_div;
    logic                wr_prot;

    assign wr_ctrl = io_wr_i && (io_addr_i == `FAC_OFS_CTRL);
    assign wr_div  = io_wr_i && (io_addr_i == `FAC_OFS_DIV);
    assign wr_prot = io_wr_i && (io_addr_i == `FAC_OFS_PROT);
    assign mem_en  = ctrl_reg[`FAC_EN_BIT];
    assign blk_idx = mem_addr_i[`FAC_BLK_MSB:`FAC_BLK_LSB]; // RULE12
    assign eff_prot = prot_reg | {7'h00, wp_sync_reg}; // RULE14
    assign blk_hit = eff_prot[blk_idx]; // RULE11

    // Register file
    always_comb
    begin
        ctrl_next  = ctrl_reg;
        div_next   = div_reg;
        prot_next  = prot_reg;
        rdata_next = rdata_reg;
        if (wr_ctrl)
        begin
            ctrl_next = io_wdata_i & `FAC_CTRL_WMASK; // RULE19
        end
        if (wr_div && key_unlocked_i && (io_wdata_i != 8'h00))
        begin
            div_next = io_wdata_i; // RULE10 RULE9
        end
        if (wr_prot)
        begin
            prot_next = key_unlocked_i ? io_wdata_i : `FAC_PROT_LOCKED; // RULE15 RULE16
        end
        if (io_rd_i)
        begin
            case (io_addr_i) // RULE5
                `FAC_OFS_CTRL: rdata_next = ctrl_reg;
                `FAC_OFS_DIV:  rdata_next = div_reg;
                `FAC_OFS_PROT: rdata_next = prot_reg;
                default:       rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            ctrl_reg  <= `FAC_CTRL_RST; // RULE3
            div_reg   <= `FAC_DIV_RST; // RULE9
            prot_reg  <= `FAC_PROT_RST; // RULE13
            rdata_reg <= 8'h00;
            wp_meta_reg <= 1'b0;
            wp_sync_reg <= 1'b0;
        end
        else
        begin
            ctrl_reg  <= ctrl_next;
            div_reg   <= div_next;
            prot_reg  <= prot_next;
            rdata_reg <= rdata_next;
            // Pin passes two flops before the protection logic reads it
            wp_meta_reg <= wp_pin_i;
            wp_sync_reg <= wp_meta_reg;
        end
    end

    // Access sequencer: counts the selected wait states, then answers
    always_comb
    begin
        state_next   = state_reg;
        wcnt_next    = wcnt_reg;
        we_lat_next  = we_lat_reg;
        hit_lat_next = hit_lat_reg;
        case (state_reg)
            fac_pkg::FAC_IDLE:
            begin
                if (mem_req_i && mem_en) // RULE4
                begin
                    state_next   = fac_pkg::FAC_WAIT;
                    wcnt_next    = ctrl_reg[`FAC_WAIT_MSB:`FAC_WAIT_LSB]; // RULE1 RULE2
                    we_lat_next  = mem_we_i;
                    hit_lat_next = blk_hit;
                end
            end
            fac_pkg::FAC_WAIT:
            begin
                if (wcnt_reg == 3'h0)
                begin
                    state_next = fac_pkg::FAC_IDLE;
                end
                else
                begin
                    wcnt_next = wcnt_reg - 3'h1;
                end
            end
            default:
            begin
                state_next = fac_pkg::FAC_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            state_reg   <= fac_pkg::FAC_IDLE;
            wcnt_reg    <= 3'h0;
            we_lat_reg  <= 1'b0;
            hit_lat_reg <= 1'b0;
        end
        else
        begin
            state_reg   <= state_next;
            wcnt_reg    <= wcnt_next;
            we_lat_reg  <= we_lat_next;
            hit_lat_reg <= hit_lat_next;
        end
    end

    assign mem_ready_o = (state_reg == fac_pkg::FAC_WAIT) && (wcnt_reg == 3'h0);
    assign mem_block_o = (state_reg == fac_pkg::FAC_IDLE) && mem_req_i && !mem_en; // RULE4

    // Controller clock enable and protection decisions
    always_comb
    begin
        dcnt_next = dcnt_reg - 8'h01;
        if ((dcnt_reg <= 8'h01) || wr_div)
        begin
            dcnt_next = div_next; // RULE20
        end
        fwr_next   = mem_ready_o && we_lat_reg && !hit_lat_reg;
        wviol_next = mem_ready_o && we_lat_reg && hit_lat_reg; // RULE18
        pgo_next   = page_erase_i && !blk_hit;
        pviol_next = page_erase_i && blk_hit; // RULE11
        mgo_next   = mass_erase_i && (eff_prot == 8'h00);
        mviol_next = mass_erase_i && (eff_prot != 8'h00);
        info_next  = mgo_next && info_page_select_i; // RULE17
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            dcnt_reg  <= `FAC_DIV_RST;
            fwr_reg   <= 1'b0;
            wviol_reg <= 1'b0;
            pgo_reg   <= 1'b0;
            pviol_reg <= 1'b0;
            mgo_reg   <= 1'b0;
            mviol_reg <= 1'b0;
            info_reg  <= 1'b0;
        end
        else
        begin
            dcnt_reg  <= dcnt_next;
            fwr_reg   <= fwr_next;
            wviol_reg <= wviol_next;
            pgo_reg   <= pgo_next;
            pviol_reg <= pviol_next;
            mgo_reg   <= mgo_next;
            mviol_reg <= mviol_next;
            info_reg  <= info_next;
        end
    end

    assign ctrl_clk_en_o     = (dcnt_reg <= 8'h01); // RULE6
    assign io_rdata_o        = rdata_reg;
    assign flash_wr_o        = fwr_reg;
    assign write_viol_o      = wviol_reg;
    assign page_erase_go_o   = pgo_reg;
    assign page_erase_viol_o = pviol_reg;
    assign mass_erase_go_o   = mgo_reg;
    assign mass_erase_viol_o = mviol_reg;
    assign info_erase_o      = info_reg;
    assign eff_protect_o     = eff_prot;
    // Helpers for the checks below
    logic [3:0] acc_cnt_reg;
    logic [2:0] wsel_reg;
    logic [8:0] gap_reg;
    logic       gap_ok_reg;
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            acc_cnt_reg <= 4'h0;
            wsel_reg    <= 3'h0;
            gap_reg     <= 9'h000;
            gap_ok_reg  <= 1'b0;
        end
        else
        begin
            if (state_reg == fac_pkg::FAC_IDLE)
            begin
                acc_cnt_reg <= 4'h0;
                wsel_reg    <= ctrl_reg[`FAC_WAIT_MSB:`FAC_WAIT_LSB];
            end
            else
            begin
                acc_cnt_reg <= acc_cnt_reg + 4'h1;
            end
            if (ctrl_clk_en_o || wr_div)
            begin
                gap_reg    <= 9'h000;
                gap_ok_reg <= ctrl_clk_en_o && !wr_div;
            end
            else
            begin
                gap_reg <= gap_reg + 9'h001;
            end
        end
    end

    a_wait_count: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE1 RULE2
        mem_ready_o |-> (acc_cnt_reg == {1'b0, wsel_reg}))
        else $error("wait state count differs from field");
    a_wait_reset: assert property (@(posedge core_clk_i) // RULE3
        ($past(rst_i) && !rst_i) |-> (ctrl_reg[`FAC_WAIT_MSB:`FAC_WAIT_LSB] == 3'h4))
        else $error("wait field not four after reset");
    a_access_gate: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE4
        (mem_req_i && !mem_en && (state_reg == fac_pkg::FAC_IDLE))
        |=> (state_reg == fac_pkg::FAC_IDLE))
        else $error("access started while disabled");
    a_io_while_off: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE5
        (io_rd_i && (io_addr_i == `FAC_OFS_PROT) && !wr_prot) |=> (io_rdata_o == prot_reg))
        else $error("register read broken");
    a_div_period: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE6 RULE20
        (ctrl_clk_en_o && gap_ok_reg) |-> ((gap_reg + 9'h001) == {1'b0, div_reg}))
        else $error("controller clock period wrong");
    a_div_range: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE9
        div_reg != 8'h00)
        else $error("divider is zero");
    a_div_locked: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE10
        (wr_div && !key_unlocked_i) |=> $stable(div_reg))
        else $error("divider written while locked");
    a_prot_write: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE15
        (wr_prot && key_unlocked_i) |=> (prot_reg == $past(io_wdata_i)))
        else $error("unlocked mask write lost");
    a_prot_force: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE16
        (wr_prot && !key_unlocked_i) |=> (prot_reg == 8'hFF))
        else $error("locked mask write not forced");
    a_boot_guard: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE14
        (page_erase_i && wp_sync_reg && (blk_idx == 3'h0)) |=> (pviol_reg && !pgo_reg))
        else $error("boot block erased under protect pin");
    a_write_viol: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE18 RULE11
        (mem_ready_o && we_lat_reg && hit_lat_reg) |=> (write_viol_o && !flash_wr_o))
        else $error("protected write performed");
    a_info_skip: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE17
        info_erase_o |-> (mass_erase_go_o && $past(info_page_select_i)))
        else $error("info page erased unselected");

endmodule // fac_top
`default_nettype wire

// File: hdl/fac_map.svh
// Register offsets, field positions and reset values of the flash access block
`ifndef FAC_MAP_SVH
`define FAC_MAP_SVH

`define FAC_OFS_CTRL    8'hF8
`define FAC_OFS_DIV     8'hF9
`define FAC_OFS_PROT    8'hFA

`define FAC_CTRL_RST    8'h88
`define FAC_CTRL_WMASK  8'hE8
`define FAC_DIV_RST     8'h01
`define FAC_PROT_RST    8'hFF
`define FAC_PROT_LOCKED 8'hFF

`define FAC_WAIT_MSB    7
`define FAC_WAIT_LSB    5
`define FAC_EN_BIT      3

`define FAC_BLK_MSB     17
`define FAC_BLK_LSB     15

`endif

// File: hdl/fac_pkg.sv
// Types of the flash access block
package fac_pkg;
    typedef enum logic [1:0] {
        FAC_IDLE = 2'b00,
        FAC_WAIT = 2'b01
    } fac_state_t;
endpackage

// File: tb/fac_cpu_model.sv
// Processor-side model: register bus, flash requests and erase pulses
`timescale 1ns/10ps
`default_nettype none
module fac_cpu_model (
    input  wire logic        clk_i,
    input  wire logic        ready_i,
    input  wire logic [7:0]  rdata_i,
    output logic      [7:0]  addr_o,
    output logic             wr_o,
    output logic             rd_o,
    output logic      [7:0]  wdata_o,
    output logic             req_o,
    output logic             we_o,
    output logic      [17:0] maddr_o,
    output logic             pe_o,
    output logic             me_o
);
    initial
    begin
        {addr_o, wr_o, rd_o, wdata_o} = 18'h00000;
        {req_o, we_o, maddr_o, pe_o, me_o} = 22'h000000;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clk_i);
        wr_o = 1'b0;
        wdata_o = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clk_i);
        rd_o = 1'b0;
        @(negedge clk_i);
        d = rdata_i;
    endtask

    // Request held until the edge that samples ready, then released
    task automatic acc(input logic we, input logic [17:0] a, output int k);
        @(negedge clk_i);
        req_o = 1'b1;
        we_o = we;
        maddr_o = a;
        for (k = 1; k < 20; k++)
        begin
            @(negedge clk_i);
            if (ready_i === 1'b1)
                break;
        end
        @(negedge clk_i);
        req_o = 1'b0;
        maddr_o = ~a;
    endtask

    task automatic raise(input logic [17:0] a);
        @(negedge clk_i);
        req_o = 1'b1;
        maddr_o = a;
    endtask

    task automatic drop;
        req_o = 1'b0;
    endtask

    task automatic er(input logic mass, input logic [17:0] a);
        @(negedge clk_i);
        maddr_o = a;
        pe_o = !mass;
        me_o = mass;
        @(negedge clk_i);
        pe_o = 1'b0;
        me_o = 1'b0;
    endtask
endmodule // fac_cpu_model
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the flash access block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic              core_clk_i = 1'b0;
    logic              rst_i = 1'b1;
    logic              key_unlocked_i = 1'b0;
    logic              wp_pin_i = 1'b0;
    logic              info_page_select_i = 1'b0;
    wire logic [7:0]   io_addr_i;
    wire logic [7:0]   io_wdata_i;
    wire logic         io_wr_i;
    wire logic         io_rd_i;
    wire logic         mem_req_i;
    wire logic         mem_we_i;
    wire logic [17:0]  mem_addr_i;
    wire logic         page_erase_i;
    wire logic         mass_erase_i;
    logic      [7:0]   io_rdata_o;
    logic      [7:0]   eff_protect_o;
    logic              mem_ready_o;
    logic              mem_block_o;
    logic              flash_wr_o;
    logic              write_viol_o;
    logic              page_erase_go_o;
    logic              page_erase_viol_o;
    logic              mass_erase_go_o;
    logic              mass_erase_viol_o;
    logic              info_erase_o;
    logic              ctrl_clk_en_o;
    int                n_fail = 0;
    int                tests_run = 0;
    int                k;
    logic      [7:0]   d;

    always #2 core_clk_i = ~core_clk_i;

    fac_top i_dut (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i),
        .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
        .key_unlocked_i(key_unlocked_i), .wp_pin_i(wp_pin_i),
        .info_page_select_i(info_page_select_i), .mem_req_i(mem_req_i), .mem_we_i(mem_we_i),
        .mem_addr_i(mem_addr_i), .mem_ready_o(mem_ready_o), .mem_block_o(mem_block_o),
        .flash_wr_o(flash_wr_o), .write_viol_o(write_viol_o), .page_erase_i(page_erase_i),
        .mass_erase_i(mass_erase_i), .page_erase_go_o(page_erase_go_o),
        .page_erase_viol_o(page_erase_viol_o), .mass_erase_go_o(mass_erase_go_o),
        .mass_erase_viol_o(mass_erase_viol_o), .info_erase_o(info_erase_o),
        .ctrl_clk_en_o(ctrl_clk_en_o), .eff_protect_o(eff_protect_o));

    fac_cpu_model i_cpu (
        .clk_i(core_clk_i), .ready_i(mem_ready_o), .rdata_i(io_rdata_o), .addr_o(io_addr_i),
        .wr_o(io_wr_i), .rd_o(io_rd_i), .wdata_o(io_wdata_i), .req_o(mem_req_i),
        .we_o(mem_we_i), .maddr_o(mem_addr_i), .pe_o(page_erase_i), .me_o(mass_erase_i));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // A bounded wait that ran out ends the run
    task automatic lim(input int v);
        if (v >= 20)
        begin
            n_fail++;
            report_and_stop();
        end
    endtask

    task automatic edge_gap;
        k = 0;
        repeat (20)
        begin
            @(negedge core_clk_i);
            k++;
            if (ctrl_clk_en_o === 1'b1)
                break;
        end
        lim(k);
    endtask

    initial
    begin
        repeat (2) @(negedge core_clk_i);
        rst_i = 1'b0;
        i_cpu.rd(8'hF8, d); check(d, 8'h88);
        i_cpu.rd(8'hF9, d); check(d, 8'h01);
        i_cpu.rd(8'hFA, d); check(d, 8'hFF);
        i_cpu.rd(8'hF7, d); check(d, 8'h00);
        i_cpu.acc(1'b0, 18'h00000, k); lim(k); check(8'(k), 8'h05);
        i_cpu.wr(8'hF9, 8'h03); i_cpu.rd(8'hF9, d); check(d, 8'h01);
        key_unlocked_i = 1'b1;
        i_cpu.wr(8'hFA, 8'h0F); i_cpu.rd(8'hFA, d); check(d, 8'h0F);
        key_unlocked_i = 1'b0;
        i_cpu.wr(8'hFA, 8'h00); i_cpu.rd(8'hFA, d); check(d, 8'hFF);
        key_unlocked_i = 1'b1;
        i_cpu.wr(8'hFA, 8'h00); check(eff_protect_o, 8'h00);
        wp_pin_i = 1'b1;
        repeat (3) @(negedge core_clk_i);
        check(eff_protect_o, 8'h01);
        i_cpu.er(1'b1, 18'h00000); check(8'(mass_erase_viol_o), 8'h01);
        i_cpu.er(1'b0, 18'h07FFF); check(8'(page_erase_viol_o), 8'h01);
        wp_pin_i = 1'b0;
        repeat (3) @(negedge core_clk_i);
        info_page_select_i = 1'b1;
        i_cpu.er(1'b1, 18'h00000); check(8'(mass_erase_go_o), 8'h01);
        check(8'(info_erase_o), 8'h01);
        info_page_select_i = 1'b0;
        i_cpu.er(1'b1, 18'h00000); check(8'(info_erase_o), 8'h00);
        i_cpu.wr(8'hF8, 8'hFF); i_cpu.rd(8'hF8, d); check(d, 8'hE8);
        for (int n = 0; n < 8; n++)
        begin
            i_cpu.wr(8'hF8, {3'(n), 5'h08});
            i_cpu.acc(1'b0, 18'h08000, k); lim(k);
            check(8'(k), 8'(n + 1));
        end
        for (int b = 0; b < 8; b++)
        begin
            i_cpu.wr(8'hFA, 8'(1 << b));
            i_cpu.acc(1'b1, 18'(b * 32768 + 32767), k); lim(k);
            check({flash_wr_o, write_viol_o}, 8'h01);
            i_cpu.acc(1'b1, 18'(((b + 1) % 8) * 32768), k); lim(k);
            check({flash_wr_o, write_viol_o}, 8'h02);
        end
        i_cpu.er(1'b0, 18'h38000); check(8'(page_erase_viol_o), 8'h01);
        i_cpu.er(1'b0, 18'h30000); check(8'(page_erase_go_o), 8'h01);
        i_cpu.er(1'b1, 18'h00000); check(8'(mass_erase_viol_o), 8'h01);
        i_cpu.wr(8'hF8, 8'h80);
        i_cpu.raise(18'h08000);
        @(negedge core_clk_i);
        check({mem_block_o, mem_ready_o}, 8'h02);
        i_cpu.drop();
        i_cpu.rd(8'hF8, d); check(d, 8'h80);
        i_cpu.wr(8'hF9, 8'h03);
        i_cpu.wr(8'hF9, 8'h00); i_cpu.rd(8'hF9, d); check(d, 8'h03);
        edge_gap();
        edge_gap(); check(8'(k), 8'h03);
        // 50 MHz system clock needs ceiling(50 x 5.1) = 255; two periods let the checker see one
        i_cpu.wr(8'hF9, 8'hFF); i_cpu.rd(8'hF9, d); check(d, 8'hFF);
        repeat (520) @(negedge core_clk_i);
        rst_i = 1'b1;
        repeat (2) @(negedge core_clk_i);
        rst_i = 1'b0;
        i_cpu.rd(8'hF8, d); check(d, 8'h88);
        i_cpu.rd(8'hF9, d); check(d, 8'h01);
        i_cpu.rd(8'hFA, d); check(d, 8'hFF);
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
